// File: rtl/queue_regs_pkg.sv
/*
 * Package for the legacy queue register bank: register offsets, sizes,
 * reset values and the structs that carry the register port and lookups.
 * Assumes one 100 MHz clock and 32-bit aligned register accesses.
 */
package queue_regs_pkg;

   // bank geometry
   localparam int unsigned NUM_QUEUES    = 4;
   localparam int unsigned QUEUE_IDX_W   = 2;
   localparam int unsigned FEATURE_WORDS = 2;
   localparam int unsigned FEAT_IDX_W    = 1;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned CAUSE_W       = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_DEVICE_FEATURE_FLAGS      = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_DEVICE_FEATURE_WORD_SELECT = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_DRIVER_FEATURE_FLAGS      = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_DRIVER_FEATURE_WORD_SELECT = 12'h024;
   localparam logic [ADDR_W-1:0] OFS_DRIVER_PAGE_SIZE          = 12'h028;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_SELECTOR            = 12'h030;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_SIZE_LIMIT          = 12'h034;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_SIZE                = 12'h038;
   localparam logic [ADDR_W-1:0] OFS_USED_RING_ALIGNMENT       = 12'h03c;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_PAGE_FRAME          = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_QUEUE_KICK                = 12'h050;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CAUSE_FLAGS           = 12'h060;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ACKNOWLEDGE           = 12'h064;
   localparam logic [ADDR_W-1:0] OFS_DEVICE_STATUS             = 12'h070;

   // reset values and limits
   localparam logic [31:0] RST_PAGE_SIZE   = 32'h0000_1000;
   localparam logic [31:0] RST_ALIGNMENT   = 32'h0000_1000;
   localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
   localparam logic [31:0] QUEUE_SIZE_MAX  = 32'h0000_0100;

   // cause bit positions
   localparam int unsigned CAUSE_USED_BUFFER   = 0;
   localparam int unsigned CAUSE_CONFIG_CHANGE = 1;

   // one register access, taken in the cycle it is presented
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } reg_req_t;

   // registered answer to a read
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } reg_rsp_t;

   // per-queue configuration handed to the ring engine
   typedef struct packed {
      logic        active;
      logic [63:0] base_addr;
      logic [31:0] size;
      logic [31:0] align;
   } queue_cfg_t;

   // queue kick towards the ring engine
   typedef struct packed {
      logic                   valid;
      logic [QUEUE_IDX_W-1:0] queue;
   } kick_t;

endpackage : queue_regs_pkg

// File: rtl/legacy_mmio_queue_registers.sv
/*
 * Legacy paravirtual transport control register bank: queue selection,
 * per-queue size, used-ring alignment and page frame, guest page size,
 * feature word selectors, driver feature flags, kicks, interrupt causes
 * and device status.
 * Assumes the driver issues only 32-bit aligned accesses, at most one
 * request per cycle, and that wr and rd are never high together.
 */
module legacy_mmio_queue_registers
   import queue_regs_pkg::*;
(
   // clock and reset
   input  wire logic                                 sys_clk_i,
   input  wire logic                                 arst_n_i,
   // register port
   input  wire reg_req_t                             reg_req_i,
   output reg_rsp_t                                  reg_rsp_o,
   // device side
   input  wire logic [FEATURE_WORDS-1:0][31:0]       device_feature_flags_i,
   input  wire logic [CAUSE_W-1:0]                   irq_event_i,
   input  wire logic [QUEUE_IDX_W-1:0]               cfg_lookup_queue_i,
   output queue_cfg_t                                cfg_lookup_o,
   output kick_t                                     kick_o,
   output logic                                      device_reset_o,
   output logic [FEATURE_WORDS-1:0][31:0]            driver_feature_flags_o,
   output logic [31:0]                               device_status_o,
   // interrupt line
   output logic                                      irq_o
);

   // whole block state
   typedef struct packed {
      logic [31:0]                      dev_feat_sel;
      logic [31:0]                      drv_feat_sel;
      logic [FEATURE_WORDS-1:0][31:0]   drv_feat;
      logic [31:0]                      page_size;
      logic [31:0]                      q_sel;
      logic [NUM_QUEUES-1:0][31:0]      q_size;
      logic [NUM_QUEUES-1:0][31:0]      q_align;
      logic [NUM_QUEUES-1:0][31:0]      q_pfn;
      logic [CAUSE_W-1:0]               cause;
      logic [31:0]                      status;
      reg_rsp_t                         rsp;
      queue_cfg_t                       lookup;
      kick_t                            kick;
      logic                             dev_reset;
      logic                             irq;
   } state_t;

   state_t st;
   state_t next_st;

   // selected-queue decode shared by reads and writes
   logic                   sel_ok;
   logic [QUEUE_IDX_W-1:0] sel_idx;
   logic                   dsel_ok;
   logic                   gsel_ok;
   logic                   wr_sel;
   logic                   wr_status0;
   logic [CAUSE_W-1:0]     ack_mask;
   logic [31:0]            rd_val;
   logic [31:0]            look_pfn;

   assign sel_ok  = (st.q_sel < 32'(NUM_QUEUES));
   assign sel_idx = st.q_sel[QUEUE_IDX_W-1:0];
   assign dsel_ok = (st.dev_feat_sel < 32'(FEATURE_WORDS));
   assign gsel_ok = (st.drv_feat_sel < 32'(FEATURE_WORDS));
   assign wr_sel  = reg_req_i.wr && sel_ok;
   assign wr_status0 = reg_req_i.wr && (reg_req_i.addr == OFS_DEVICE_STATUS)
                       && (reg_req_i.wdata == RST_ZERO);
   assign look_pfn = st.q_pfn[cfg_lookup_queue_i];

   // acknowledge mask, only the defined cause bits count
   always_comb begin
      ack_mask = '0;
      if (reg_req_i.wr && (reg_req_i.addr == OFS_IRQ_ACKNOWLEDGE)) begin
         ack_mask = reg_req_i.wdata[CAUSE_W-1:0];
      end
   end

   // read mux; write-only and unmapped offsets read as zero
   always_comb begin
      rd_val = RST_ZERO;
      case (reg_req_i.addr)
         OFS_DEVICE_FEATURE_FLAGS: begin
            if (dsel_ok) begin
               rd_val = device_feature_flags_i[st.dev_feat_sel[FEAT_IDX_W-1:0]];
            end
         end
         OFS_QUEUE_SIZE_LIMIT: begin
            rd_val = sel_ok ? QUEUE_SIZE_MAX : RST_ZERO;
         end
         OFS_QUEUE_PAGE_FRAME: begin
            rd_val = sel_ok ? st.q_pfn[sel_idx] : RST_ZERO;
         end
         OFS_IRQ_CAUSE_FLAGS: begin
            rd_val = {{(32-CAUSE_W){1'b0}}, st.cause};
         end
         OFS_DEVICE_STATUS: begin
            rd_val = st.status;
         end
         default: begin
            rd_val = RST_ZERO;
         end
      endcase
   end

   // next-state logic
   always_comb begin
      next_st = st;
      next_st.kick.valid = 1'b0;
      next_st.dev_reset  = 1'b0;

      // read answer, one cycle after the request
      next_st.rsp.valid = reg_req_i.rd;
      next_st.rsp.data  = reg_req_i.rd ? rd_val : RST_ZERO;

      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            OFS_DEVICE_FEATURE_WORD_SELECT: begin
               next_st.dev_feat_sel = reg_req_i.wdata;
            end
            OFS_DRIVER_FEATURE_WORD_SELECT: begin
               next_st.drv_feat_sel = reg_req_i.wdata;
            end
            OFS_DRIVER_FEATURE_FLAGS: begin
               // selector out of range drops the write; nothing to hold it
               if (gsel_ok) begin
                  next_st.drv_feat[st.drv_feat_sel[FEAT_IDX_W-1:0]] = reg_req_i.wdata;
               end
            end
            OFS_DRIVER_PAGE_SIZE: begin
               next_st.page_size = reg_req_i.wdata;
            end
            OFS_QUEUE_SELECTOR: begin
               next_st.q_sel = reg_req_i.wdata;
            end
            OFS_QUEUE_SIZE: begin
               if (wr_sel) begin
                  next_st.q_size[sel_idx] = reg_req_i.wdata;
               end
            end
            OFS_USED_RING_ALIGNMENT: begin
               if (wr_sel) begin
                  next_st.q_align[sel_idx] = reg_req_i.wdata;
               end
            end
            OFS_QUEUE_PAGE_FRAME: begin
               if (wr_sel) begin
                  next_st.q_pfn[sel_idx] = reg_req_i.wdata;
               end
            end
            OFS_QUEUE_KICK: begin
               // kicks for queues that do not exist are dropped
               if (reg_req_i.wdata < 32'(NUM_QUEUES)) begin
                  next_st.kick.valid = 1'b1;
                  next_st.kick.queue = reg_req_i.wdata[QUEUE_IDX_W-1:0];
               end
            end
            OFS_DEVICE_STATUS: begin
               next_st.status = reg_req_i.wdata;
            end
            default: begin
               next_st.status = st.status;
            end
         endcase
      end

      // zero status write: device reset, every page frame cleared
      if (wr_status0) begin
         next_st.dev_reset = 1'b1;
         next_st.status    = RST_ZERO;
         for (int q = 0; q < NUM_QUEUES; q++) begin
            next_st.q_pfn[q] = RST_ZERO;
         end
      end

      // causes: a new event wins over an acknowledge or reset in the same cycle
      if (wr_status0) begin
         next_st.cause = irq_event_i;
      end else begin
         next_st.cause = (st.cause & ~ack_mask) | irq_event_i;
      end
      next_st.irq = |next_st.cause;

      // lookup of a queue for the ring engine, base = frame * page size
      next_st.lookup.active    = (look_pfn != RST_ZERO);
      next_st.lookup.base_addr = 64'(look_pfn) * 64'(st.page_size);
      next_st.lookup.size      = st.q_size[cfg_lookup_queue_i];
      next_st.lookup.align     = st.q_align[cfg_lookup_queue_i];
   end

   // state register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st              <= '0;
         st.page_size    <= RST_PAGE_SIZE;
         st.q_align      <= {NUM_QUEUES{RST_ALIGNMENT}};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops
   assign reg_rsp_o              = st.rsp;
   assign cfg_lookup_o           = st.lookup;
   assign kick_o                 = st.kick;
   assign device_reset_o         = st.dev_reset;
   assign driver_feature_flags_o = st.drv_feat;
   assign device_status_o        = st.status;
   assign irq_o                  = st.irq;

endmodule : legacy_mmio_queue_registers

// File: dv/queue_regs_properties.sv
/* port assertions for the queue register bank.
   assumes it is bound to legacy_mmio_queue_registers, one clock domain. */
module queue_regs_checker
   import queue_regs_pkg::*;
(
   // clock and reset
   input wire logic               sys_clk_i,
   input wire logic               arst_n_i,
   // watched ports
   input wire reg_req_t           reg_req_i,
   input wire reg_rsp_t           reg_rsp_o,
   input wire logic [CAUSE_W-1:0] irq_event_i,
   input wire kick_t              kick_o,
   input wire queue_cfg_t         cfg_lookup_o,
   input wire logic               device_reset_o,
   input wire logic [31:0]        device_status_o,
   input wire logic               irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] sel;
   wire         wr = reg_req_i.wr;
   wire [11:0]  ad = reg_req_i.addr;
   wire         st0 = wr && ad == OFS_DEVICE_STATUS && reg_req_i.wdata == RST_ZERO;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   // shadow selector; only the bus reset clears it, as in the bank, where a zero status write keeps the selector
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) sel <= '0;
      else if (wr && ad == OFS_QUEUE_SELECTOR) sel <= reg_req_i.wdata;
   end

   read_answer_a: assert property (reg_req_i.rd |=> reg_rsp_o.valid)
      else $error("read not answered next cycle");
   stray_answer_a: assert property (!reg_req_i.rd |=> !reg_rsp_o.valid)
      else $error("answer without read");
   size_limit_a: assert property (reg_req_i.rd && ad == OFS_QUEUE_SIZE_LIMIT |=>
      reg_rsp_o.data == (sel < NUM_QUEUES ? QUEUE_SIZE_MAX : RST_ZERO))
      else $error("size limit wrong for selected queue");
   kick_pulse_a: assert property (wr && ad == OFS_QUEUE_KICK && reg_req_i.wdata < 4
      |=> kick_o.valid && kick_o.queue == $past(reg_req_i.wdata[1:0]))
      else $error("kick missing or wrong queue");
   stray_kick_a: assert property (!(wr && ad == OFS_QUEUE_KICK) |=> !kick_o.valid)
      else $error("kick without write");
   status_reset_a: assert property (st0 |=> device_reset_o && device_status_o == RST_ZERO)
      else $error("zero status write did not reset");
   frames_cleared_a: assert property (st0 |-> ##2 !cfg_lookup_o.active)
      else $error("queue still active after reset");
   event_irq_a: assert property (|irq_event_i |=> irq_o)
      else $error("event did not raise interrupt");
   irq_holds_a: assert property (irq_o && !(wr && (ad == OFS_IRQ_ACKNOWLEDGE || st0))
      |=> irq_o) else $error("interrupt dropped without acknowledge");
   ack_clears_a: assert property (wr && ad == OFS_IRQ_ACKNOWLEDGE && irq_event_i == '0
      && reg_req_i.wdata[1:0] == 2'h3 |=> !irq_o) else $error("acknowledge did not clear");
endmodule : queue_regs_checker

bind legacy_mmio_queue_registers queue_regs_checker queue_regs_checker_inst (.sys_clk_i,
   .arst_n_i, .reg_req_i, .reg_rsp_o, .irq_event_i, .kick_o, .cfg_lookup_o,
   .device_reset_o, .device_status_o, .irq_o);

// File: dv/legacy_mmio_queue_registers_tb.sv
/* self-checking bench for the queue register bank, driving its register port.
   assumes the one-cycle read answer and registered outputs of the bank. */
module legacy_mmio_queue_registers_tb;
   import queue_regs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, arst_n_i, dres, irq;
   reg_req_t req;
   reg_rsp_t rsp;
   logic [FEATURE_WORDS-1:0][31:0] dff, dfo;
   logic [CAUSE_W-1:0] ev;
   logic [1:0] lq;
   queue_cfg_t cfg;
   kick_t kick;
   logic [31:0] dst, pf;
   int err_count = 0, num_checks = 0;

   legacy_mmio_queue_registers legacy_mmio_queue_registers_inst (.sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i), .reg_req_i(req), .reg_rsp_o(rsp), .device_feature_flags_i(dff),
      .irq_event_i(ev), .cfg_lookup_queue_i(lq), .cfg_lookup_o(cfg), .kick_o(kick),
      .device_reset_o(dres), .driver_feature_flags_o(dfo), .device_status_o(dst),
      .irq_o(irq));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [128:0] got, input logic [128:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one idle cycle between accesses keeps each request a single-cycle strobe
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(negedge sys_clk_i);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk_i);
      req = '0;
   endtask : wr_reg

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      @(negedge sys_clk_i);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge sys_clk_i);
      req = '0;
      chk({rsp.valid, rsp.data}, {1'b1, e});
   endtask : rd_chk

   task automatic look(input logic [1:0] q);
      @(negedge sys_clk_i);
      lq = q;
      @(negedge sys_clk_i);
   endtask : look

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // hang guard
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_count++;
      tally_and_finish();
   end

   initial begin
      req = '0;
      ev = '0;
      lq = '0;
      arst_n_i = 1'b0;
      dff = {32'hcafe0001, 32'h1234abcd};
      repeat (4) @(posedge sys_clk_i);
      chk({irq, kick.valid, dres, rsp.valid}, 4'h0);
      @(negedge sys_clk_i);
      arst_n_i = 1'b1;
      wr_reg(OFS_DRIVER_PAGE_SIZE, 32'h2000);
      // selector 4 is absent: its writes must not alias onto queue 0
      for (int q = 0; q < 5; q++) begin
         wr_reg(OFS_QUEUE_SELECTOR, 32'(q));
         rd_chk(OFS_QUEUE_SIZE_LIMIT, q < 4 ? QUEUE_SIZE_MAX : RST_ZERO);
         wr_reg(OFS_QUEUE_SIZE, 32'h10 << q);
         wr_reg(OFS_USED_RING_ALIGNMENT, 32'h4 << q);
         wr_reg(OFS_QUEUE_PAGE_FRAME, 32'(17 * (q + 1)));
      end
      for (int q = 0; q < 4; q++) begin
         pf = 32'(17 * (q + 1));
         wr_reg(OFS_QUEUE_SELECTOR, 32'(q));
         rd_chk(OFS_QUEUE_PAGE_FRAME, pf);
         look(2'(q));
         chk(cfg, {1'b1, 64'(pf) * 64'h2000, 32'h10 << q, 32'h4 << q});
      end
      // selector still on queue 3: retire it and see it go inactive
      wr_reg(OFS_QUEUE_PAGE_FRAME, RST_ZERO);
      rd_chk(OFS_QUEUE_PAGE_FRAME, RST_ZERO);
      look(2'h3);
      chk(cfg.active, 1'b0);
      rd_chk(OFS_QUEUE_SIZE, RST_ZERO);
      rd_chk(12'h0fc, RST_ZERO);
      for (int w = 0; w < 2; w++) begin
         wr_reg(OFS_DEVICE_FEATURE_WORD_SELECT, 32'(w));
         rd_chk(OFS_DEVICE_FEATURE_FLAGS, dff[w]);
         wr_reg(OFS_DRIVER_FEATURE_WORD_SELECT, 32'(w));
         wr_reg(OFS_DRIVER_FEATURE_FLAGS, 32'h5a0 + 32'(w));
      end
      chk(dfo, {32'h5a1, 32'h5a0});
      for (int q = 0; q < 4; q++) begin
         wr_reg(OFS_QUEUE_KICK, 32'(q));
         chk({kick.valid, kick.queue}, {1'b1, 2'(q)});
      end
      @(negedge sys_clk_i);
      ev = 2'h2;
      @(negedge sys_clk_i);
      ev = 2'h0;
      chk(irq, 1'b1);
      rd_chk(OFS_IRQ_CAUSE_FLAGS, 32'h2);
      wr_reg(OFS_IRQ_ACKNOWLEDGE, 32'h1);
      chk(irq, 1'b1);
      wr_reg(OFS_IRQ_ACKNOWLEDGE, 32'h3);
      rd_chk(OFS_IRQ_CAUSE_FLAGS, RST_ZERO);
      chk(irq, 1'b0);
      wr_reg(OFS_DEVICE_STATUS, 32'h7);
      rd_chk(OFS_DEVICE_STATUS, 32'h7);
      wr_reg(OFS_DEVICE_STATUS, RST_ZERO);
      chk(dres, 1'b1);
      wr_reg(OFS_QUEUE_SELECTOR, 32'h2);
      rd_chk(OFS_QUEUE_PAGE_FRAME, RST_ZERO);
      look(2'h1);
      chk(cfg.active, 1'b0);
      tally_and_finish();
   end
endmodule : legacy_mmio_queue_registers_tb
